//--- rtl/bbs_switch.sv
// Purpose: Supply mode control with serial gating, shared pin and status.
// Assumes: Comparators are analog and outside, synchronised here; other inputs are synchronous.
// Notes:   Registers sit on an Avalon-MM slave with one wait cycle.
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
module bbs_switch (
  // Clock and reset.
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  // Avalon-MM register slave.
  input  wire logic [bbs_pkg::BBS_ADDR_W-1:0] avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [bbs_pkg::BBS_DATA_W-1:0] avs_writedata,
  output logic      [bbs_pkg::BBS_DATA_W-1:0] avs_readdata,
  output logic                              avs_waitrequest,
  output logic                              irq,
  // Supply comparators.
  input  wire bbs_pkg::bbs_cmp_s            cmp_in,
  output logic                              trip_cmp_enable,
  output logic                              battery_select,
  // Timebase and alarm.
  input  wire logic                         osc_level,
  input  wire logic                         crystal_input,
  input  wire logic                         alarm_active,
  // Serial bus pins and the serial engine side.
  input  wire logic                         scl_in,
  input  wire logic                         sda_in,
  output logic                              sda_out,
  output logic                              sda_oe,
  input  wire logic                         engine_sda_low,
  output logic                              engine_scl,
  output logic                              engine_sda,
  // Shared alarm or frequency pin.
  output logic                              alarm_or_freq_pin_out,
  output logic                              alarm_or_freq_pin_oe
);
  import bbs_pkg::*;

  bbs_mode_e                 mode;
  bbs_ctrl_s                 ctrl;
  bbs_cmp_s                  cmp_sync1;
  bbs_cmp_s                  cmp_sync2;
  bbs_cmp_s                  cmp_prev;
  bbs_cmp_s                  cmp_stable;
  logic                      armed;
  logic                      total_power_loss_flag;
  logic [BBS_IRQ_W-1:0]      irq_stat;
  logic [BBS_IRQ_W-1:0]      irq_mask;
  logic [BBS_IRQ_W-1:0]      irq_event;
  logic                      alarm_prev;
  logic                      tb_level;
  logic                      tb_prev;
  logic [BBS_DIV_W-1:0]      tb_div;
  logic                      freq_level;
  logic                      enter_cond;
  logic                      exit_cond;
  logic                      outputs_off;
  logic                      wr_done;
  logic [BBS_DATA_W-1:0]     next_readdata;

  // Comparator crossing: two-stage synchroniser, then a stability filter.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cmp_sync1  <= '0;
      cmp_sync2  <= '0;
      cmp_prev   <= '0;
      cmp_stable <= '0;
    end else begin
      cmp_sync1 <= cmp_in;
      cmp_sync2 <= cmp_sync1;
      cmp_prev  <= cmp_sync2;
      if (cmp_sync2 == cmp_prev) begin
        cmp_stable <= cmp_sync2;
      end
    end
  end

  // In low-power switching the trip comparison plays no part.
  assign enter_cond = ctrl.low_power_switching
                    ? cmp_stable.vdd_below_bat
                    : (cmp_stable.vdd_below_bat &&
                       cmp_stable.vdd_below_trip);
  assign exit_cond  = cmp_stable.vdd_above_bat ||
                      (!ctrl.low_power_switching &&
                       cmp_stable.vdd_above_trip);

  // Supply mode; the battery is untouched until main power has been seen.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode  <= BBS_ST_UNPOWERED;
      armed <= 1'b0;
    end else begin
      unique case (mode)
        BBS_ST_UNPOWERED: begin
          if (exit_cond) begin
            mode  <= BBS_ST_NORMAL;
            armed <= 1'b1;
          end
        end
        BBS_ST_NORMAL: begin
          if (enter_cond) begin
            mode <= BBS_ST_BATTERY;
          end
        end
        BBS_ST_BATTERY: begin
          if (exit_cond) begin
            mode <= BBS_ST_NORMAL;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      battery_select  <= 1'b0;
      trip_cmp_enable <= 1'b1;
    end else begin
      battery_select  <= (mode == BBS_ST_BATTERY);
      trip_cmp_enable <= !ctrl.low_power_switching;
    end
  end

  // Serial gating: in backup the engine sees an idle bus.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      engine_scl <= 1'b1;
      engine_sda <= 1'b1;
      sda_out    <= 1'b0;
      sda_oe     <= 1'b0;
    end else begin
      engine_scl <= (mode == BBS_ST_BATTERY) ? 1'b1 : scl_in;
      engine_sda <= (mode == BBS_ST_BATTERY) ? 1'b1 : sda_in;
      sda_out    <= 1'b0;
      sda_oe     <= engine_sda_low && (mode == BBS_ST_NORMAL);
    end
  end

  // Timebase select and frequency divider.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tb_level <= 1'b0;
      tb_prev  <= 1'b0;
      tb_div   <= '0;
    end else begin
      tb_level <= ctrl.ext_timebase ? crystal_input : osc_level;
      tb_prev  <= tb_level;
      if (tb_level && !tb_prev) begin
        tb_div <= tb_div + 1'b1;
      end
    end
  end

  // Select 1 passes the timebase; select n divides it by 2 to the n-1.
  always_comb begin
    if (ctrl.freq_sel <= 4'h1) begin
      freq_level = tb_level;
    end else begin
      freq_level = tb_div[ctrl.freq_sel - 4'h2];
    end
  end

  assign outputs_off = ctrl.backup_outputs_off &&
                       (mode == BBS_ST_BATTERY);

  // Shared open-drain pin: only the enable moves, the level stays low.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      alarm_or_freq_pin_out <= 1'b0;
      alarm_or_freq_pin_oe  <= 1'b0;
    end else begin
      alarm_or_freq_pin_out <= 1'b0;
      if (outputs_off) begin
        alarm_or_freq_pin_oe <= 1'b0;
      end else if (ctrl.freq_sel != '0) begin
        alarm_or_freq_pin_oe <= !freq_level;
      end else begin
        alarm_or_freq_pin_oe <= alarm_active;
      end
    end
  end

  // Avalon slave: one wait cycle per access; data stands at the done edge.
  assign wr_done = avs_write && !avs_waitrequest;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  always_comb begin
    next_readdata = '0;
    unique case (avs_address)
      BBS_OFS_CTRL: begin
        next_readdata[6:0] = ctrl;
      end
      BBS_OFS_STATUS: begin
        next_readdata[BBS_ST_BACKUP] = (mode == BBS_ST_BATTERY);
        next_readdata[BBS_ST_ARMED]  = armed;
        next_readdata[BBS_ST_PLOSS]  = total_power_loss_flag;
        next_readdata[BBS_ST_CMP+:4] = cmp_stable;
      end
      BBS_OFS_IRQ_STAT: begin
        next_readdata[BBS_IRQ_W-1:0] = irq_stat;
      end
      BBS_OFS_IRQ_MASK: begin
        next_readdata[BBS_IRQ_W-1:0] = irq_mask;
      end
      default: begin
        next_readdata = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      avs_readdata <= '0;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= next_readdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl     <= BBS_CTRL_RST;
      irq_mask <= BBS_IRQ_RST;
    end else if (wr_done) begin
      if (avs_address == BBS_OFS_CTRL) begin
        ctrl <= avs_writedata[6:0];
      end
      if (avs_address == BBS_OFS_IRQ_MASK) begin
        irq_mask <= avs_writedata[BBS_IRQ_W-1:0];
      end
    end
  end

  // Cold start leaves the flag set; only a write of one clears it.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      total_power_loss_flag <= BBS_PLOSS_RST;
    end else if (wr_done && avs_address == BBS_OFS_STATUS &&
                 avs_writedata[BBS_ST_PLOSS]) begin
      total_power_loss_flag <= 1'b0;
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle.
  always_comb begin
    irq_event = '0;
    irq_event[BBS_IRQ_ENTER]  = (mode == BBS_ST_NORMAL) && enter_cond;
    irq_event[BBS_IRQ_RETURN] = (mode == BBS_ST_BATTERY) && exit_cond;
    irq_event[BBS_IRQ_ALARM]  = alarm_active && !alarm_prev;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_stat   <= BBS_IRQ_RST;
      alarm_prev <= 1'b0;
      irq        <= 1'b0;
    end else begin
      alarm_prev <= alarm_active;
      if (wr_done && avs_address == BBS_OFS_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~avs_writedata[BBS_IRQ_W-1:0]) | irq_event;
      end else begin
        irq_stat <= irq_stat | irq_event;
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

  a_backup_entry_cond: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (mode == BBS_ST_NORMAL && !ctrl.low_power_switching &&
     cmp_stable.vdd_below_bat && cmp_stable.vdd_below_trip)
    |=> mode == BBS_ST_BATTERY)
    else $error("normal mode did not enter backup on both conditions");

  a_backup_needs_both: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (mode == BBS_ST_NORMAL && !ctrl.low_power_switching &&
     !cmp_stable.vdd_below_trip) |=> mode != BBS_ST_BATTERY)
    else $error("backup entered without trip condition");

  a_backup_exit_any: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (mode == BBS_ST_BATTERY && cmp_stable.vdd_above_bat)
    |=> mode == BBS_ST_NORMAL)
    else $error("backup did not return to normal");

  a_trip_exit_normal: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (mode == BBS_ST_BATTERY && !ctrl.low_power_switching &&
     cmp_stable.vdd_above_trip) |=> mode == BBS_ST_NORMAL)
    else $error("backup did not leave on trip recovery");

  a_serial_gated: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (mode == BBS_ST_BATTERY) ##1 (mode == BBS_ST_BATTERY)
    |-> !sda_oe && engine_scl && engine_sda)
    else $error("serial bus active in backup");

  a_pin_backup_off: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    outputs_off |=> !alarm_or_freq_pin_oe)
    else $error("shared pin driven while disabled in backup");

  a_loss_flag_hold: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (total_power_loss_flag && !(wr_done &&
     avs_address == BBS_OFS_STATUS)) |=> total_power_loss_flag)
    else $error("power loss flag dropped without a clear");

  a_lp_ignore_trip: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (mode == BBS_ST_NORMAL && ctrl.low_power_switching &&
     cmp_stable.vdd_below_bat) |=> mode == BBS_ST_BATTERY)
    else $error("low power switching did not enter backup");

  a_no_battery_first: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !armed |-> mode != BBS_ST_BATTERY && !battery_select)
    else $error("battery used before first main power-up");

  a_irq_mode_pin: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (ctrl.freq_sel == '0 && !outputs_off && alarm_active)
    |=> alarm_or_freq_pin_oe && !alarm_or_freq_pin_out)
    else $error("alarm not signalled on shared pin");

  a_sda_open_drain: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    sda_oe |-> !sda_out && $past(engine_sda_low))
    else $error("serial data driven other than low");

  a_cmp_two_stable: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $changed(cmp_stable) |-> $past(cmp_sync2) == cmp_stable &&
    $past(cmp_prev) == cmp_stable)
    else $error("comparator accepted without stability");

endmodule

//--- shared/bbs_pkg.sv
// Purpose: Shared constants and types for the backup supply switch control.
// Assumes: Byte addressed 32-bit register words on the Avalon-MM slave.
// Notes:   Offsets, field positions and reset values live here only.
package bbs_pkg;

  localparam int unsigned BBS_ADDR_W = 8;
  localparam int unsigned BBS_DATA_W = 32;

  localparam logic [7:0] BBS_OFS_CTRL     = 8'h00;
  localparam logic [7:0] BBS_OFS_STATUS   = 8'h04;
  localparam logic [7:0] BBS_OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] BBS_OFS_IRQ_MASK = 8'h0c;

  // Control register fields.
  localparam int unsigned BBS_CTRL_LP     = 0;
  localparam int unsigned BBS_CTRL_FO_LSB = 1;
  localparam int unsigned BBS_CTRL_BKOFF  = 5;
  localparam int unsigned BBS_CTRL_EXTTB  = 6;
  localparam logic [6:0]  BBS_CTRL_RST    = 7'h00;

  // Status register fields.
  localparam int unsigned BBS_ST_BACKUP = 0;
  localparam int unsigned BBS_ST_ARMED  = 1;
  localparam int unsigned BBS_ST_PLOSS  = 2;
  localparam int unsigned BBS_ST_CMP    = 4;

  // Interrupt status and mask fields.
  localparam int unsigned BBS_IRQ_W      = 3;
  localparam int unsigned BBS_IRQ_ENTER  = 0;
  localparam int unsigned BBS_IRQ_RETURN = 1;
  localparam int unsigned BBS_IRQ_ALARM  = 2;
  localparam logic [2:0]  BBS_IRQ_RST    = 3'h0;

  localparam logic        BBS_PLOSS_RST  = 1'b1;
  localparam int unsigned BBS_FO_W       = 4;
  localparam int unsigned BBS_DIV_W      = 14;

  typedef enum logic [2:0] {
    BBS_ST_UNPOWERED = 3'b001,
    BBS_ST_NORMAL    = 3'b010,
    BBS_ST_BATTERY   = 3'b100
  } bbs_mode_e;

  // Analog comparator results, each high while the relation holds.
  typedef struct packed {
    logic vdd_below_bat;   // Main below battery minus hysteresis.
    logic vdd_above_bat;   // Main above battery plus hysteresis.
    logic vdd_below_trip;  // Main below trip threshold.
    logic vdd_above_trip;  // Main above trip threshold plus hysteresis.
  } bbs_cmp_s;

  typedef struct packed {
    logic                ext_timebase;
    logic                backup_outputs_off;
    logic [BBS_FO_W-1:0] freq_sel;
    logic                low_power_switching;
  } bbs_ctrl_s;

endpackage

//--- test/bbs_supply_model.sv
// Purpose: Model of the supply comparators and the two timebase sources.
// Assumes: Supply levels are given in millivolts by the bench.
// Notes:   The crystal input runs four times faster than the oscillator.
`timescale 1ns/1ns
module bbs_supply_model (
  // Clock.
  input  wire logic        core_clk,
  // Supply levels in millivolts.
  input  wire logic [15:0] vdd_mv,
  input  wire logic [15:0] bat_mv,
  // Comparator results and timebase levels.
  output bbs_pkg::bbs_cmp_s cmp,
  output logic             osc_level,
  output logic             crystal_input
);
  import bbs_pkg::*;
  localparam logic [15:0] BAT_HYS  = 16'd50;
  localparam logic [15:0] TRIP     = 16'd2200;
  localparam logic [15:0] TRIP_HYS = 16'd30;
  logic [3:0] div = 4'h0;
  assign cmp.vdd_below_bat  = vdd_mv < bat_mv - BAT_HYS;
  assign cmp.vdd_above_bat  = vdd_mv > bat_mv + BAT_HYS;
  assign cmp.vdd_below_trip = vdd_mv < TRIP;
  assign cmp.vdd_above_trip = vdd_mv > TRIP + TRIP_HYS;
  always @(posedge core_clk) begin
    div <= div + 4'h1;
  end
  assign osc_level     = div[3];
  assign crystal_input = div[1];
endmodule

//--- test/bbs_switch_tb.sv
// Purpose: Self-checking bench for the backup supply switch control.
// Assumes: Supply levels in millivolts feed the comparator model.
// Notes:   Seeded random serial traffic follows the corner cases.
`timescale 1ns/1ns
module bbs_switch_tb;
  import bbs_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic [7:0]  adr      = 8'h00;
  logic        rd       = 1'b0;
  logic        wr       = 1'b0;
  logic [31:0] wd       = 32'h0;
  logic [31:0] rdat, q;
  logic        wreq, irq, trip_en, bat_sel, osc, xin, pl;
  bbs_cmp_s    cmp;
  logic        alarm    = 1'b0;
  logic        scl      = 1'b1;
  logic        esl      = 1'b0;
  logic        sda_o, sda_oe, e_scl, e_sda, pin_o, pin_oe;
  logic [15:0] vdd      = 16'd0;
  logic [15:0] bat      = 16'd3000;
  logic [31:0] seed     = 32'haef3e67e;
  logic [31:0] r;
  int          errors   = 0;
  int          n_checks = 0;
  int          cnt;
  wire         sda_in   = ~sda_oe;

  always #4 core_clk = ~core_clk;

  bbs_supply_model sup_u (.core_clk(core_clk), .vdd_mv(vdd), .bat_mv(bat),
    .cmp(cmp), .osc_level(osc), .crystal_input(xin));

  bbs_switch dut_u (.core_clk(core_clk), .rst_n(rst_n), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .irq(irq), .cmp_in(cmp),
    .trip_cmp_enable(trip_en), .battery_select(bat_sel), .osc_level(osc),
    .crystal_input(xin), .alarm_active(alarm), .scl_in(scl),
    .sda_in(sda_in), .sda_out(sda_o), .sda_oe(sda_oe),
    .engine_sda_low(esl), .engine_scl(e_scl), .engine_sda(e_sda),
    .alarm_or_freq_pin_out(pin_o), .alarm_or_freq_pin_oe(pin_oe));

  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // True when a rise count is within one of span over the pin period.
  function automatic logic near(input int got, input int span,
                                input int per);
    near = (got >= span / per - 1) && (got <= span / per + 1);
  endfunction

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    rd  <= ~w;
    wr  <= w;
    adr <= a;
    wd  <= d;
    do begin
      @(posedge core_clk);
    end while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // Levels reach the comparators off the sampling edge, then settle.
  task automatic supply(input int mv);
    @(posedge core_clk);
    vdd <= mv[15:0];
    repeat (12) @(posedge core_clk);
    #1;
  endtask

  task automatic rises(input int n);
    cnt = 0;
    pl  = pin_oe;
    repeat (n) begin
      @(posedge core_clk);
      #1;
      if (pin_oe === 1'b1 && pl === 1'b0) cnt++;
      pl = pin_oe;
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    chk("battery_select", bat_sel, 0);
    chk("trip_cmp_enable", trip_en, 1);
    bus(0, BBS_OFS_STATUS, 0);
    chk("status", q[2:0], 3'b100);
    bus(0, BBS_OFS_CTRL, 0);
    chk("ctrl", q, 0);
    bus(0, BBS_OFS_IRQ_MASK, 0);
    chk("irq_mask", q, 0);
    bus(0, 8'h40, 0);
    chk("unmapped", q, 0);
    $display("test reset done");
    supply(1000);
    chk("battery_select", bat_sel, 0);
    supply(3300);
    bus(0, BBS_OFS_STATUS, 0);
    chk("armed", q[1], 1);
    bus(1, BBS_OFS_IRQ_MASK, 32'h3);
    supply(2900);
    chk("battery_select", bat_sel, 0);
    @(posedge core_clk);
    scl <= 1'b0;
    esl <= 1'b1;
    supply(2100);
    chk("battery_select", bat_sel, 1);
    chk("irq", irq, 1);
    chk("engine_scl", e_scl, 1);
    chk("sda_oe", sda_oe, 0);
    chk("engine_sda", e_sda, 1);
    @(posedge core_clk);
    alarm <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk("pin_oe", pin_oe, 1);
    chk("pin_out", pin_o, 0);
    bus(1, BBS_OFS_CTRL, 32'h20);
    repeat (3) @(posedge core_clk);
    #1;
    chk("pin_oe", pin_oe, 0);
    bus(1, BBS_OFS_CTRL, 0);
    alarm <= 1'b0;
    bus(1, BBS_OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge core_clk);
    #1;
    chk("irq", irq, 0);
    supply(2240);
    chk("battery_select", bat_sel, 0);
    @(posedge core_clk);
    bat <= 16'd1500;
    supply(1400);
    chk("battery_select", bat_sel, 1);
    supply(1530);
    chk("battery_select", bat_sel, 1);
    supply(1600);
    chk("battery_select", bat_sel, 0);
    bus(1, BBS_OFS_IRQ_MASK, 0);
    repeat (2) @(posedge core_clk);
    #1;
    chk("irq", irq, 0);
    bus(1, BBS_OFS_IRQ_STAT, 32'h7);
    bus(0, BBS_OFS_IRQ_STAT, 0);
    chk("irq_stat", q[1:0], 0);
    $display("test switching done");
    bat <= 16'd3000;
    supply(3300);
    bus(1, BBS_OFS_CTRL, 32'h1);
    repeat (3) @(posedge core_clk);
    #1;
    chk("trip_cmp_enable", trip_en, 0);
    supply(2900);
    chk("battery_select", bat_sel, 1);
    supply(3300);
    bus(1, BBS_OFS_STATUS, 32'h4);
    bus(0, BBS_OFS_STATUS, 0);
    chk("loss_flag", q[2], 0);
    bus(1, BBS_OFS_CTRL, 32'h2);
    rises(64);
    chk("osc_rises", near(cnt, 64, 16), 1);
    bus(1, BBS_OFS_CTRL, 32'h42);
    rises(64);
    chk("xtal_rises", near(cnt, 64, 4), 1);
    bus(1, BBS_OFS_CTRL, 32'h44);
    rises(64);
    chk("div_rises", near(cnt, 64, 8), 1);
    bus(1, BBS_OFS_CTRL, 32'h0);
    rises(64);
    chk("int_rises", cnt, 0);
    $display("test pin done");
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    bus(0, BBS_OFS_STATUS, 0);
    chk("loss_flag", q[2], 1);
    supply(3300);
    chk("battery_select", bat_sel, 0);
    $display("test restart done");
    pl = esl;
    repeat (200) begin
      r = $random(seed);
      @(posedge core_clk);
      esl <= r[0];
      scl <= r[1];
      @(posedge core_clk);
      #1;
      chk("sda_oe", sda_oe, r[0]);
      chk("sda_out", sda_o, 0);
      chk("engine_scl", e_scl, r[1]);
      chk("engine_sda", e_sda, !pl);
      pl = r[0];
    end
    $display("test random done");
    end_sim();
  end
endmodule
